/* hdl/cg_clock_gen.v */
`timescale 1ns/1ps
`include "cg_clock_map.vh"
module cg_clock_gen (
   // Clock and reset.
   input wire CLOCK_IN,
   input wire RESET_N_IN,
   // APB slave.
   input wire PSEL_IN,
   input wire PENABLE_IN,
   input wire PWRITE_IN,
   input wire [7:0] PADDR_IN,
   input wire [31:0] PWDATA_IN,
   output reg [31:0] PRDATA_OUT,
   output reg PREADY_OUT,
   output reg PSLVERR_OUT,
   // Interrupt.
   output reg IRQ_OUT,
   // Stop mode, comparator and external pin.
   input wire STOP_MODE_IN,
   input wire CMP_VALID_IN,
   input wire [1:0] CMP_RESULT_IN,
   input wire EXT_CLK_PIN_IN,
   // Generated clocks.
   output reg INT_CLK_OUT,
   output reg BASE_CLK_OUT,
   output reg EXT_CLK_OUT,
   output reg OSC_OUT_CLK_OUT,
   output reg GEN_OUT_CLK_OUT,
   output reg TIMEBASE_CLK_OUT,
   // Enables and status.
   output reg GEN_STOP_OUT,
   output reg INT_GEN_ENABLE_OUT,
   output reg EXT_GEN_ENABLE_OUT,
   output reg PIN_A_PORT_ENABLE_OUT,
   output reg PIN_B_PORT_ENABLE_OUT,
   output reg FILTER_STABLE_FLAG_OUT,
   output reg [11:0] OSC_CODE_OUT
);
   localparam [2:0] ST_IDLE = 3'b001;
   localparam [2:0] ST_ACCESS = 3'b010;
   localparam [2:0] ST_DONE = 3'b100;

   // Register state.
   reg [2:0] ctrl_q;
   reg [2:0] cfg_q;
   reg [7:0] multiplier_reg_q;
   reg [`CG_IRQ_WIDTH-1:0] irq_stat_q;
   reg [`CG_IRQ_WIDTH-1:0] irq_stat_d;
   reg [`CG_IRQ_WIDTH-1:0] irq_mask_q;
   reg [2:0] bus_state_q;

   // Oscillator model state.
   reg [6:0] osc_count_q;
   reg int_clk_q;
   reg int_clk_prev_q;
   reg osc_src_prev_q;
   reg stable_prev_q;
   reg range_prev_q;

   wire [11:0] code;
   wire stable;
   wire base_clk;

   function is_addr;
      input [7:0] addr;
      input [7:0] ofs;
      begin
         is_addr = (addr == ofs);
      end
   endfunction

   function [3:0] eff_div;
      input [3:0] div;
      begin
         eff_div = (div > `CG_DIV_MAX) ? `CG_DIV_MAX : div;
      end
   endfunction

   wire int_gen_on_bit = ctrl_q[`CG_CTRL_INT_ON];
   wire ext_gen_on_bit = ctrl_q[`CG_CTRL_EXT_ON];
   wire osc_run_in_stop = cfg_q[`CG_CFG_RUN_IN_STOP];
   wire ext_clk_allowed = cfg_q[`CG_CFG_EXT_ALLOWED];
   wire crystal_allowed = cfg_q[`CG_CFG_XTAL_ALLOWED];

   wire gen_stop = STOP_MODE_IN & ~osc_run_in_stop;
   wire int_gen_enable = int_gen_on_bit & ~gen_stop;
   wire ext_gen_enable = ext_gen_on_bit & ~gen_stop;

   wire setup = PSEL_IN & ~PENABLE_IN;
   wire commit = PSEL_IN & PENABLE_IN & PREADY_OUT;
   wire wr = commit & PWRITE_IN;
   wire rd_stat = commit & ~PWRITE_IN & is_addr(PADDR_IN, `CG_OFS_IRQ_STAT);
   wire mapped = is_addr(PADDR_IN, `CG_OFS_CTRL) | is_addr(PADDR_IN, `CG_OFS_CFG) |
                 is_addr(PADDR_IN, `CG_OFS_MULT) | is_addr(PADDR_IN, `CG_OFS_STATUS) |
                 is_addr(PADDR_IN, `CG_OFS_IRQ_STAT) | is_addr(PADDR_IN, `CG_OFS_IRQ_MASK);

   // Half period in system clocks grows with the effective code, whose divider field saturates at CG_DIV_MAX, so a larger code is slower up to 12'h9ff.
   wire [3:0] div_eff = eff_div(code[11:8]);
   wire [6:0] half_period = {div_eff, code[7:5]};

   wire int_rise = int_clk_q & ~int_clk_prev_q;
   wire osc_src = (ctrl_q[`CG_CTRL_SEL_EXT] & ext_gen_enable) ? EXT_CLK_OUT : int_clk_q;
   wire osc_rise = osc_src & ~osc_src_prev_q;
   wire out_of_range = code[11:8] > `CG_DIV_MAX;
   wire [`CG_IRQ_WIDTH-1:0] events = {out_of_range & ~range_prev_q, stable & ~stable_prev_q};

   cg_mod_divider u_divider (
      .clk_in(CLOCK_IN),
      .reset_n_in(RESET_N_IN),
      .enable_in(int_gen_enable),
      .factor_in(multiplier_reg_q),
      .src_level_in(int_clk_q),
      .src_rise_in(int_rise),
      .base_out(base_clk)
   );

   cg_loop_filter u_filter (
      .clk_in(CLOCK_IN),
      .reset_n_in(RESET_N_IN),
      .enable_in(int_gen_enable),
      .cmp_valid_in(CMP_VALID_IN),
      .cmp_result_in(CMP_RESULT_IN),
      .code_out(code),
      .stable_out(stable)
   );

   // Bus sequencing: answer is ready in the access cycle after every setup.
   always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         bus_state_q <= ST_IDLE;
         PREADY_OUT <= 1'b0;
         PSLVERR_OUT <= 1'b0;
         PRDATA_OUT <= 32'h00000000;
      end else begin
         case (bus_state_q)
            ST_IDLE, ST_DONE: begin
               bus_state_q <= ST_IDLE;
               if (setup) begin
                  bus_state_q <= ST_ACCESS;
                  PREADY_OUT <= 1'b1;
                  PSLVERR_OUT <= ~mapped;
                  PRDATA_OUT <= 32'h00000000;
                  if (!PWRITE_IN) begin
                     case (1'b1)
                        is_addr(PADDR_IN, `CG_OFS_CTRL): PRDATA_OUT <= {29'h0, ctrl_q};
                        is_addr(PADDR_IN, `CG_OFS_CFG): PRDATA_OUT <= {29'h0, cfg_q};
                        is_addr(PADDR_IN, `CG_OFS_MULT): PRDATA_OUT <= {24'h0, multiplier_reg_q};
                        is_addr(PADDR_IN, `CG_OFS_STATUS): PRDATA_OUT <= {16'h0, gen_stop, ext_gen_enable,
                                                                 int_gen_enable, stable, code};
                        // The next status value is shown, so an event landing at the setup edge is read out before the clear.
                        is_addr(PADDR_IN, `CG_OFS_IRQ_STAT): PRDATA_OUT <= {30'h0, irq_stat_d};
                        is_addr(PADDR_IN, `CG_OFS_IRQ_MASK): PRDATA_OUT <= {30'h0, irq_mask_q};
                        default: PRDATA_OUT <= 32'h00000000;
                     endcase
                  end
               end
            end
            ST_ACCESS: begin
               bus_state_q <= ST_DONE;
               PREADY_OUT <= 1'b0;
               PSLVERR_OUT <= 1'b0;
            end
            default: begin
               bus_state_q <= ST_IDLE;
               PREADY_OUT <= 1'b0;
               PSLVERR_OUT <= 1'b0;
            end
         endcase
      end
   end

   // Software registers. The external on-bit keeps its old value if the write is not allowed.
   always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ctrl_q <= `CG_CTRL_RESET;
         cfg_q <= `CG_CFG_RESET;
         multiplier_reg_q <= `CG_MULT_RESET;
         irq_mask_q <= {`CG_IRQ_WIDTH{1'b0}};
      end else if (wr) begin
         if (is_addr(PADDR_IN, `CG_OFS_CTRL)) begin
            ctrl_q[`CG_CTRL_INT_ON] <= PWDATA_IN[`CG_CTRL_INT_ON];
            ctrl_q[`CG_CTRL_SEL_EXT] <= PWDATA_IN[`CG_CTRL_SEL_EXT];
            if (!PWDATA_IN[`CG_CTRL_EXT_ON] || ext_clk_allowed) begin
               ctrl_q[`CG_CTRL_EXT_ON] <= PWDATA_IN[`CG_CTRL_EXT_ON];
            end
         end
         if (is_addr(PADDR_IN, `CG_OFS_CFG)) begin
            cfg_q <= PWDATA_IN[2:0];
         end
         if (is_addr(PADDR_IN, `CG_OFS_MULT)) begin
            multiplier_reg_q <= PWDATA_IN[7:0];
         end
         if (is_addr(PADDR_IN, `CG_OFS_IRQ_MASK)) begin
            irq_mask_q <= PWDATA_IN[`CG_IRQ_WIDTH-1:0];
         end
      end
   end

   // Sticky events: a new event in the read cycle survives the read-clear.
   always @* begin
      irq_stat_d = irq_stat_q;
      if (rd_stat) begin
         irq_stat_d = {`CG_IRQ_WIDTH{1'b0}};
      end
      irq_stat_d = irq_stat_d | events;
   end

   always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         irq_stat_q <= {`CG_IRQ_WIDTH{1'b0}};
         IRQ_OUT <= 1'b0;
         stable_prev_q <= 1'b0;
         range_prev_q <= 1'b0;
      end else begin
         irq_stat_q <= irq_stat_d;
         IRQ_OUT <= |(irq_stat_d & irq_mask_q);
         stable_prev_q <= stable;
         range_prev_q <= out_of_range;
      end
   end

   // Oscillator model: toggles the internal clock after a code-dependent half period.
   always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         osc_count_q <= 7'h00;
         int_clk_q <= 1'b0;
         int_clk_prev_q <= 1'b0;
      end else begin
         int_clk_prev_q <= int_clk_q;
         if (!int_gen_enable) begin
            osc_count_q <= 7'h00;
            int_clk_q <= 1'b0;
         end else if (osc_count_q >= half_period) begin
            osc_count_q <= 7'h00;
            int_clk_q <= ~int_clk_q;
         end else begin
            osc_count_q <= osc_count_q + 7'h01;
         end
      end
   end

   // Clock outputs, enables and pin sharing.
   always @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         osc_src_prev_q <= 1'b0;
         INT_CLK_OUT <= 1'b0;
         BASE_CLK_OUT <= 1'b0;
         EXT_CLK_OUT <= 1'b0;
         OSC_OUT_CLK_OUT <= 1'b0;
         GEN_OUT_CLK_OUT <= 1'b0;
         TIMEBASE_CLK_OUT <= 1'b0;
         GEN_STOP_OUT <= 1'b0;
         INT_GEN_ENABLE_OUT <= 1'b0;
         EXT_GEN_ENABLE_OUT <= 1'b0;
         PIN_A_PORT_ENABLE_OUT <= 1'b1;
         PIN_B_PORT_ENABLE_OUT <= 1'b1;
         FILTER_STABLE_FLAG_OUT <= 1'b0;
         OSC_CODE_OUT <= `CG_CODE_RESET;
      end else begin
         osc_src_prev_q <= osc_src;
         INT_CLK_OUT <= int_clk_q & int_gen_enable;
         BASE_CLK_OUT <= base_clk & int_gen_enable;
         EXT_CLK_OUT <= EXT_CLK_PIN_IN & ext_gen_enable;
         OSC_OUT_CLK_OUT <= osc_src;
         // Generator output toggles on each oscillator rise, so it halves the oscillator output.
         if (osc_rise) begin
            GEN_OUT_CLK_OUT <= ~GEN_OUT_CLK_OUT;
         end
         TIMEBASE_CLK_OUT <= ext_gen_enable ? EXT_CLK_OUT : int_clk_q;
         GEN_STOP_OUT <= gen_stop;
         INT_GEN_ENABLE_OUT <= int_gen_enable;
         EXT_GEN_ENABLE_OUT <= ext_gen_enable;
         // Port enables ignore stop so the pins stay with the oscillator during stop mode.
         PIN_A_PORT_ENABLE_OUT <= ~ext_gen_on_bit;
         PIN_B_PORT_ENABLE_OUT <= ~(ext_gen_on_bit & crystal_allowed);
         FILTER_STABLE_FLAG_OUT <= stable;
         OSC_CODE_OUT <= code;
      end
   end
endmodule // cg_clock_gen

/* hdl/cg_clock_map.vh */
`ifndef CG_CLOCK_MAP_VH
`define CG_CLOCK_MAP_VH

// Register byte offsets on the APB bus.
`define CG_OFS_CTRL 8'h00
`define CG_OFS_CFG 8'h04
`define CG_OFS_MULT 8'h08
`define CG_OFS_STATUS 8'h0c
`define CG_OFS_IRQ_STAT 8'h10
`define CG_OFS_IRQ_MASK 8'h14

// Control register fields.
`define CG_CTRL_INT_ON 0
`define CG_CTRL_EXT_ON 1
`define CG_CTRL_SEL_EXT 2

// Configuration register fields.
`define CG_CFG_RUN_IN_STOP 0
`define CG_CFG_EXT_ALLOWED 1
`define CG_CFG_XTAL_ALLOWED 2

// Interrupt status and mask fields.
`define CG_IRQ_STABLE 0
`define CG_IRQ_RANGE 1
`define CG_IRQ_WIDTH 2

// Reset values.
`define CG_CTRL_RESET 3'h1
`define CG_CFG_RESET 3'h0
`define CG_MULT_RESET 8'h01
`define CG_CODE_RESET 12'h400

// Loop filter code layout and limits.
`define CG_CODE_WIDTH 12
`define CG_DIV_MAX 4'h9
`define CG_STEP_BIG 12'h020
`define CG_STEP_SMALL 12'h001

// Comparator result encoding.
`define CG_CMP_BELOW_LOW 2'h0
`define CG_CMP_BELOW_NOM 2'h1
`define CG_CMP_ABOVE_NOM 2'h2
`define CG_CMP_ABOVE_HIGH 2'h3

`endif

/* hdl/cg_mod_divider.v */
`timescale 1ns/1ps
module cg_mod_divider (
   // Clock and reset.
   input wire clk_in,
   input wire reset_n_in,
   // Control.
   input wire enable_in,
   input wire [7:0] factor_in,
   // Source clock level and its rising-edge tick.
   input wire src_level_in,
   input wire src_rise_in,
   // Divided clock.
   output reg base_out
);
   reg [7:0] count_q;
   wire bypass = (factor_in == 8'h00) || (factor_in == 8'h01);
   wire [7:0] half = {1'b0, factor_in[7:1]};

   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         count_q <= 8'h00;
         base_out <= 1'b0;
      end else if (!enable_in) begin
         count_q <= 8'h00;
         base_out <= 1'b0;
      end else if (bypass) begin
         count_q <= 8'h00;
         base_out <= src_level_in;
      end else if (src_rise_in) begin
         if (count_q >= factor_in - 8'h01) begin
            count_q <= 8'h00;
         end else begin
            count_q <= count_q + 8'h01;
         end
         base_out <= (count_q >= factor_in - 8'h01) || (count_q < half - 8'h01);
      end
   end
endmodule // cg_mod_divider

/* hdl/cg_loop_filter.v */
`timescale 1ns/1ps
`include "cg_clock_map.vh"
module cg_loop_filter (
   // Clock and reset.
   input wire clk_in,
   input wire reset_n_in,
   // Comparator evaluation.
   input wire enable_in,
   input wire cmp_valid_in,
   input wire [1:0] cmp_result_in,
   // Oscillator code and stability.
   output reg [11:0] code_out,
   output reg stable_out
);
   reg [11:0] step;

   always @* begin
      case (cmp_result_in)
         `CG_CMP_BELOW_LOW: step = 12'h000 - `CG_STEP_BIG;
         `CG_CMP_BELOW_NOM: step = 12'h000 - `CG_STEP_SMALL;
         `CG_CMP_ABOVE_NOM: step = `CG_STEP_SMALL;
         default: step = `CG_STEP_BIG;
      endcase
   end

   // The sum wraps modulo 4096 on purpose; codes wrapped below zero land in the slow range.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         code_out <= `CG_CODE_RESET;
         stable_out <= 1'b0;
      end else if (enable_in && cmp_valid_in) begin
         code_out <= code_out + step;
         stable_out <= (cmp_result_in == `CG_CMP_BELOW_NOM) || (cmp_result_in == `CG_CMP_ABOVE_NOM);
      end else if (!enable_in) begin
         stable_out <= 1'b0;
      end
   end
endmodule // cg_loop_filter

/* verif/cg_clock_gen_asserts.sv */
`timescale 1ns/1ps
module cg_clock_gen_asserts (
   // Clock and reset.
   input wire CLOCK_IN,
   input wire RESET_N_IN,
   // Watched ports.
   input wire STOP_MODE_IN,
   input wire CMP_VALID_IN,
   input wire [1:0] CMP_RESULT_IN,
   input wire EXT_CLK_PIN_IN,
   input wire INT_CLK_OUT,
   input wire BASE_CLK_OUT,
   input wire EXT_CLK_OUT,
   input wire TIMEBASE_CLK_OUT,
   input wire GEN_STOP_OUT,
   input wire INT_GEN_ENABLE_OUT,
   input wire EXT_GEN_ENABLE_OUT,
   input wire PIN_A_PORT_ENABLE_OUT,
   input wire PIN_B_PORT_ENABLE_OUT,
   input wire FILTER_STABLE_FLAG_OUT,
   input wire [11:0] OSC_CODE_OUT
);
   default clocking @(posedge CLOCK_IN); endclocking
   default disable iff (!RESET_N_IN);
   function automatic [11:0] step(input [1:0] r);
      step = (r == 2'h0) ? 12'hfe0 : (r == 2'h1) ? 12'hfff : (r == 2'h2) ? 12'h001 : 12'h020;
   endfunction
   // A lone pulse, so no earlier correction is still on its way to the output.
   sequence s_lone_pulse;
      CMP_VALID_IN && !$past(CMP_VALID_IN);
   endsequence
   // The enable output lags the enable that the filter uses by one clock.
   sequence s_pulse;
      s_lone_pulse ##1 INT_GEN_ENABLE_OUT;
   endsequence
   property p_code_step;
      s_pulse |-> ##1 OSC_CODE_OUT == $past(OSC_CODE_OUT, 2) + step($past(CMP_RESULT_IN, 2));
   endproperty
   chk_code_step: assert property (p_code_step)
      else $error("code step wrong");
   chk_stable_band: assert property (s_pulse |-> ##1 FILTER_STABLE_FLAG_OUT == ^$past(CMP_RESULT_IN, 2))
      else $error("stable flag wrong");
   chk_ext_follow: assert property (EXT_GEN_ENABLE_OUT |-> EXT_CLK_OUT == $past(EXT_CLK_PIN_IN))
      else $error("external clock not following pin");
   chk_code_hold: assert property (!INT_GEN_ENABLE_OUT [*3] |-> $stable(OSC_CODE_OUT))
      else $error("code moved while disabled");
   chk_int_low: assert property (!INT_GEN_ENABLE_OUT [*3] |-> !INT_CLK_OUT && !BASE_CLK_OUT)
      else $error("internal clocks not low");
   chk_ext_low: assert property (!EXT_GEN_ENABLE_OUT [*3] |-> !EXT_CLK_OUT)
      else $error("external clock not low");
   chk_stop_gates: assert property (GEN_STOP_OUT [*2] |-> !INT_GEN_ENABLE_OUT && !EXT_GEN_ENABLE_OUT)
      else $error("enable during stop");
   chk_stop_cause: assert property (GEN_STOP_OUT |-> $past(STOP_MODE_IN) || $past(STOP_MODE_IN, 2))
      else $error("stop without stop mode");
   chk_pin_a_ext: assert property (EXT_GEN_ENABLE_OUT && $past(EXT_GEN_ENABLE_OUT) |-> !PIN_A_PORT_ENABLE_OUT)
      else $error("first pin port enabled");
   chk_pin_b_ext: assert property (!PIN_B_PORT_ENABLE_OUT |-> !PIN_A_PORT_ENABLE_OUT)
      else $error("second pin without ext on");
   chk_timebase_src: assert property (EXT_GEN_ENABLE_OUT [*3] |-> TIMEBASE_CLK_OUT == $past(EXT_CLK_OUT))
      else $error("timebase not external");
endmodule // cg_clock_gen_asserts

bind cg_clock_gen cg_clock_gen_asserts cg_clock_gen_asserts_i (.CLOCK_IN, .RESET_N_IN, .STOP_MODE_IN,
   .CMP_VALID_IN, .CMP_RESULT_IN, .EXT_CLK_PIN_IN, .INT_CLK_OUT, .BASE_CLK_OUT, .EXT_CLK_OUT, .TIMEBASE_CLK_OUT,
   .GEN_STOP_OUT, .INT_GEN_ENABLE_OUT, .EXT_GEN_ENABLE_OUT, .PIN_A_PORT_ENABLE_OUT,
   .PIN_B_PORT_ENABLE_OUT, .FILTER_STABLE_FLAG_OUT, .OSC_CODE_OUT);

/* verif/cg_sys_model.sv */
`timescale 1ns/1ps
module cg_sys_model (
   // Clock and reset.
   input wire clk_in,
   input wire reset_n_in,
   // Generated clocks.
   input wire osc_clk_in,
   input wire gen_clk_in,
   // Edge counts.
   output reg [15:0] osc_rises_out,
   output reg [15:0] gen_rises_out
);
   reg osc_q;
   reg gen_q;
   // Both clocks are sampled on clk_in, so the gen rise count against osc rises shows the ratio.
   always @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         osc_q <= 1'b0;
         gen_q <= 1'b0;
         osc_rises_out <= 16'h0000;
         gen_rises_out <= 16'h0000;
      end else begin
         osc_q <= osc_clk_in;
         gen_q <= gen_clk_in;
         osc_rises_out <= osc_rises_out + {15'h0000, osc_clk_in & ~osc_q};
         gen_rises_out <= gen_rises_out + {15'h0000, gen_clk_in & ~gen_q};
      end
   end
endmodule // cg_sys_model

/* verif/cg_clock_gen_tb.sv */
`timescale 1ns/1ps
`include "cg_clock_map.vh"
module cg_clock_gen_tb;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg psel = 1'b0;
   reg pen = 1'b0;
   reg pwr = 1'b0;
   reg stop = 1'b0;
   reg cv = 1'b0;
   reg pin = 1'b0;
   reg bq = 1'b0;
   reg err;
   reg [1:0] cr = 2'h0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h00000000;
   reg [31:0] rdat;
   reg [31:0] rv;
   reg [11:0] exp_code = 12'h400;
   wire [31:0] prdata;
   wire pready, pslverr, irq, int_clk, bclk, ext_clk, oclk, gclk, tclk, gstop, ien, een, pa, pb, stb;
   wire [11:0] code;
   wire [15:0] orise, grise;
   integer fail_count = 0, checks_done = 0, brise = 0, i, n, o, g, b;
   always #20 clk = ~clk;
   always @(posedge clk) begin
      pin <= ^$urandom;
      bq <= bclk;
      if (bclk && !bq) brise <= brise + 1;
   end
   cg_clock_gen cg_clock_gen_i (.CLOCK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen),
      .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
      .PSLVERR_OUT(pslverr), .IRQ_OUT(irq), .STOP_MODE_IN(stop), .CMP_VALID_IN(cv), .CMP_RESULT_IN(cr),
      .EXT_CLK_PIN_IN(pin), .INT_CLK_OUT(int_clk), .BASE_CLK_OUT(bclk), .EXT_CLK_OUT(ext_clk),
      .OSC_OUT_CLK_OUT(oclk), .GEN_OUT_CLK_OUT(gclk), .TIMEBASE_CLK_OUT(tclk), .GEN_STOP_OUT(gstop),
      .INT_GEN_ENABLE_OUT(ien), .EXT_GEN_ENABLE_OUT(een), .PIN_A_PORT_ENABLE_OUT(pa),
      .PIN_B_PORT_ENABLE_OUT(pb), .FILTER_STABLE_FLAG_OUT(stb), .OSC_CODE_OUT(code));
   cg_sys_model cg_sys_model_i (.clk_in(clk), .reset_n_in(rst_n), .osc_clk_in(oclk), .gen_clk_in(gclk),
      .osc_rises_out(orise), .gen_rises_out(grise));
   function [11:0] step(input [1:0] r);
      step = (r == 2'h0) ? 12'hfe0 : (r == 2'h1) ? 12'hfff : (r == 2'h2) ? 12'h001 : 12'h020;
   endfunction
   task check(input string nm, input [31:0] seen, input [31:0] exp);
      checks_done = checks_done + 1;
      if (seen !== exp) begin
         fail_count = fail_count + 1;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      integer t;
      t = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && t < 20) begin
         @(posedge clk);
         t = t + 1;
      end
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      if (t == 20) begin
         fail_count = fail_count + 1;
         end_of_test;
      end
   endtask
   task pulse(input [1:0] r);
      @(posedge clk);
      cv <= 1'b1;
      cr <= r;
      @(posedge clk);
      cv <= 1'b0;
      exp_code = exp_code + step(r);
      repeat (3) @(posedge clk);
      check("code", code, exp_code);
      check("stable", stb, r[0] ^ r[1]);
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      #(40 * 20000);
      fail_count = fail_count + 1;
      end_of_test;
   end
   initial begin
      rv = $urandom(32'hfcb2);
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      apb(1'b0, `CG_OFS_STATUS, 0);
      check("status", rdat, 32'h00002400);
      apb(1'b0, 8'h18, 0);
      check("unmapped", {rdat[30:0], err}, 1);
      apb(1'b1, `CG_OFS_CTRL, 3);
      apb(1'b0, `CG_OFS_CTRL, 0);
      check("ext on refused", rdat, 1);
      // Thirty-two big steps down land exactly on the fastest code.
      for (i = 0; i < 32; i = i + 1) pulse(2'h0);
      pulse(2'h1);
      apb(1'b0, `CG_OFS_STATUS, 0);
      check("wrapped code", rdat[11:0], 12'hfff);
      check("masked irq", irq, 0);
      apb(1'b1, `CG_OFS_IRQ_MASK, 2);
      repeat (3) @(posedge clk);
      check("irq", irq, 1);
      apb(1'b0, `CG_OFS_IRQ_STAT, 0);
      check("irq status", rdat, 3);
      repeat (3) @(posedge clk);
      check("irq cleared", irq, 0);
      pulse(2'h2);
      for (i = 0; i < 5; i = i + 1) begin
         n = (i < 4) ? i : 5;
         apb(1'b1, `CG_OFS_MULT, n);
         repeat (20) @(posedge clk);
         o = orise;
         g = grise;
         b = brise;
         repeat (400) @(posedge clk);
         o = orise - o;
         g = grise - g;
         b = brise - b;
         if (n < 2) n = 1;
         check("base ratio", (b * n + n + 2 > o) && (o + n + 2 > b * n), 1);
         check("gen ratio", (2 * g + 3 > o) && (o + 3 > 2 * g), 1);
      end
      for (i = 0; i < 40; i = i + 1) begin
         rv = $urandom;
         pulse(rv[1:0]);
      end
      apb(1'b1, `CG_OFS_CFG, 2);
      apb(1'b1, `CG_OFS_CTRL, 3);
      repeat (4) @(posedge clk);
      check("ports", {een, pa, pb}, 3'h5);
      apb(1'b1, `CG_OFS_CFG, 6);
      repeat (4) @(posedge clk);
      check("second pin", pb, 0);
      stop <= 1'b1;
      repeat (6) @(posedge clk);
      check("stopped", {gstop, ien, een, int_clk, ext_clk, pa}, 6'h20);
      // The pulse adds its step to the expectation, so take it back first: a disabled filter holds.
      exp_code = exp_code - 12'h020;
      pulse(2'h3);
      check("held code", code, exp_code);
      apb(1'b1, `CG_OFS_CFG, 7);
      repeat (4) @(posedge clk);
      check("run in stop", {gstop, ien, een}, 3'h3);
      apb(1'b1, `CG_OFS_CTRL, 7);
      repeat (20) @(posedge clk);
      o = orise;
      g = grise;
      repeat (400) @(posedge clk);
      o = orise - o;
      g = grise - g;
      check("ext osc running", o > 20, 1);
      check("ext gen ratio", (2 * g + 3 > o) && (o + 3 > 2 * g), 1);
      stop <= 1'b0;
      end_of_test;
   end
endmodule // cg_clock_gen_tb
